/* pcc_pkg.sv */
// Constants and carrier types for the POST-code capture FIFO block
// Behaviour
// - All block logic runs from the one system clock.
// - Block held in reset on low standby, low power-good or host interface reset.
// - Interrupt asserted while FIFO entry count is at or above threshold.
// - Interrupt produced whenever enabled; no mask inside this block.
// - Sixteen 32-bit FIFO entries plus a 24-bit timestamp counter that runs only while on and timer-enabled.
// - Each host code write joins byte with timer value and pushes it.
// - Reads of the host code byte register return zero.
// - Write into full FIFO drops oldest entry, stores new, sets overflow.
// - Only the controller reads FIFO contents, through its data register.
// - Block off: host writes unclaimed, FIFO empty, timer zero and stopped.
// - Configuration control bits keep their value whatever the block-on bit.
// - Block-on bit is bit 0 at controller offset 330h, host index 30h.
// - Controller may also write the host code byte register.
// - Controller registers decode at 100h, 104h, 108h and 10Ch.
// - Threshold field 3,2,1,0 selects 14, 8, 4, 1 entries.
// - Timer ticks every 8, 16, 32 or 64 clocks for rate 0 to 3.
// - Count register write loads the timer; read returns its value.
// - Overflow status set by write into full FIFO; not-empty while data held.
package pcc_pkg;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned ENTRY_W    = 32;
   localparam int unsigned TIME_W     = 24;
   localparam int unsigned CODE_W     = 8;
   // Controller-side offsets and host configuration index
   localparam logic [11:0] OFS_HOST_CODE = 12'h000;
   localparam logic [11:0] OFS_FIFO_OUT  = 12'h100;
   localparam logic [11:0] OFS_CFG       = 12'h104;
   localparam logic [11:0] OFS_STATE     = 12'h108;
   localparam logic [11:0] OFS_COUNT     = 12'h10C;
   localparam logic [11:0] OFS_ACTIVATE  = 12'h330;
   localparam logic [7:0]  IDX_ACTIVATE  = 8'h30;
   // Field positions
   localparam int unsigned CFG_THR_LSB  = 6;
   localparam int unsigned CFG_TMR_BIT  = 5;
   localparam int unsigned CFG_RATE_LSB = 3;
   localparam int unsigned CFG_RSTS_BIT = 2;
   localparam int unsigned CFG_FLSH_BIT = 1;
   localparam int unsigned ST_OVR_BIT   = 1;
   localparam int unsigned ST_NE_BIT    = 0;
   localparam int unsigned CNT_LSB      = 8;
   localparam int unsigned ACT_BIT      = 0;
   // Threshold levels and tick divisors per select value
   localparam logic [4:0] THR_LVL0 = 5'h01;
   localparam logic [4:0] THR_LVL1 = 5'h04;
   localparam logic [4:0] THR_LVL2 = 5'h08;
   localparam logic [4:0] THR_LVL3 = 5'h0E;
   localparam logic [6:0] DIV_SEL0 = 7'h08;
   localparam logic [6:0] DIV_SEL1 = 7'h10;
   localparam logic [6:0] DIV_SEL2 = 7'h20;
   localparam logic [6:0] DIV_SEL3 = 7'h40;
   localparam logic       ACT_RST  = 1'h0;
   // One captured code with its timestamp
   typedef struct packed {
      logic [23:0] capture_time;
      logic [7:0]  drained_byte;
   } pcc_entry_t;
   // Configuration control bits
   typedef struct packed {
      logic [1:0] thr;
      logic       tmr_en;
      logic [1:0] tick_rate_sel;
   } pcc_cfg_t;
   localparam pcc_cfg_t CFG_RST = '{thr: 2'h0, tmr_en: 1'h0, tick_rate_sel: 2'h0};
endpackage

/* pcc_capture.sv */
// FIFO and top level of the POST-code capture block
`timescale 1ns/1ns
`default_nettype none

// Entry FIFO with valid/ready on both sides and flush
module pcc_fifo #(
   parameter int unsigned W     = 32,
   parameter int unsigned DEPTH = 16,
   parameter int unsigned AW    = $clog2(DEPTH)
) (
   input  wire logic          sys_clk_i,   // System clock
   input  wire logic          sys_rst_i,   // Synchronous reset
   input  wire logic          flush_i,     // Empty the FIFO
   input  wire logic          in_valid_i,  // Write request
   output logic               in_ready_o,  // Space, or a pop frees one
   input  wire logic [W-1:0]  in_data_i,   // Write data
   output logic               out_valid_o, // Entry available
   input  wire logic          out_ready_i, // Pop request
   output logic [W-1:0]       out_data_o,  // Oldest entry
   output logic [AW:0]        count_o      // Entries held
);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic          push;
   logic          pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("pcc_fifo depth must be a power of two");
   end

   // Handshake terms; a pop in the same cycle makes room when full
   assign in_ready_o  = (count_o != FULL_CNT) | out_ready_i;
   assign out_valid_o = (count_o != '0);
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   assign out_data_o  = mem[rd_ptr];

   // Storage
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Pointers and count
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || flush_i) begin
         wr_ptr  <= '0;
         rd_ptr  <= '0;
         count_o <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count_o <= count_o + 1'b1;
         end else if (pop && !push) begin
            count_o <= count_o - 1'b1;
         end
      end
   end
endmodule // pcc_fifo

// POST-code capture: host code port, controller registers, timer, FIFO
module pcc_capture import pcc_pkg::*; #(
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   input  wire logic        sys_clk_i,        // System clock
   input  wire logic        sys_rst_i,        // Synchronous reset, active high
   input  wire logic        standby_supply_i, // Standby supply good, pin
   input  wire logic        power_good_in_i,  // Power good, pin
   input  wire logic        host_if_reset_i,  // Host interface in reset, pin
   input  wire logic        host_wr_i,        // Host I/O write to code byte
   input  wire logic        host_rd_i,        // Host I/O read of code byte
   input  wire logic [7:0]  host_wdata_i,     // Host code byte
   output logic             host_claim_o,     // Cycle claimed
   output logic [7:0]       host_rdata_o,     // Host read data
   input  wire logic        cfg_wr_i,         // Config write, device selected
   input  wire logic        cfg_rd_i,         // Config read, device selected
   input  wire logic [7:0]  cfg_index_i,      // Config register index
   input  wire logic [7:0]  cfg_wdata_i,      // Config write data
   output logic [7:0]       cfg_rdata_o,      // Config read data
   input  wire logic        ec_req_i,         // Controller access strobe
   input  wire logic        ec_wr_i,          // Controller write
   input  wire logic [11:0] ec_addr_i,        // Controller byte offset
   input  wire logic [31:0] ec_wdata_i,       // Controller write data
   output logic             ec_ack_o,         // Access done
   output logic [31:0]      ec_rdata_o,       // Controller read data
   output logic             post_code_irq_o   // Fill-level interrupt
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   if (DEPTH < 16 || (1 << AW) != DEPTH) begin : g_chk
      $error("pcc_capture depth must be a power of two, at least 16");
   end

   logic [2:0]        pin_meta;
   logic [2:0]        pin_sync;
   logic              blk_rst;
   logic              act;
   pcc_cfg_t          cfg;
   logic              overrun;
   logic [6:0]        presc;
   logic [TIME_W-1:0] timer;
   logic [6:0]        div_val;
   logic [AW:0]       thr_lvl;
   logic              ec_wr;
   logic              ec_rd;
   logic              code_wr;
   logic [7:0]        code_byte;
   logic              full;
   logic              drop;
   logic              ec_pop;
   logic              cnt_ld;
   logic              ts_clr;
   logic              flush;
   logic              run;
   logic              tick;
   pcc_entry_t        in_ent;
   pcc_entry_t        head;
   logic              in_rdy;
   logic              head_vld;
   logic [AW:0]       fcount;

   // Two-stage synchronisers for the reset source pins
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         pin_meta <= 3'h1;
         pin_sync <= 3'h1;
      end else begin
         pin_meta <= {standby_supply_i, power_good_in_i, host_if_reset_i};
         pin_sync <= pin_meta;
      end
   end

   // Block reset from any reset source
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         blk_rst <= 1'b1;
      end else begin
         blk_rst <= !pin_sync[2] || !pin_sync[1] || pin_sync[0];
      end
   end

   // Access decode
   assign ec_wr     = ec_req_i & ec_wr_i;
   assign ec_rd     = ec_req_i & ~ec_wr_i;
   assign code_wr   = act & (host_wr_i | (ec_wr && ec_addr_i == OFS_HOST_CODE));
   assign code_byte = host_wr_i ? host_wdata_i : ec_wdata_i[7:0];
   assign full      = (fcount == FULL_CNT);
   assign drop      = code_wr & full;
   assign ec_pop    = ec_rd && ec_addr_i == OFS_FIFO_OUT && head_vld;
   assign cnt_ld    = ec_wr && ec_addr_i == OFS_COUNT;
   assign ts_clr    = ec_wr && ec_addr_i == OFS_CFG && ec_wdata_i[CFG_RSTS_BIT];
   assign flush     = !act || (ec_wr && ec_addr_i == OFS_CFG && ec_wdata_i[CFG_FLSH_BIT]);
   assign run       = act & cfg.tmr_en;
   assign tick      = run && presc == div_val - 7'h01;

   // Code byte joined with the timestamp
   assign in_ent = '{capture_time: timer, drained_byte: code_byte};

   // Level and divisor decode
   always_comb begin
      case (cfg.thr)
         2'h0:    thr_lvl = (AW+1)'(THR_LVL0);
         2'h1:    thr_lvl = (AW+1)'(THR_LVL1);
         2'h2:    thr_lvl = (AW+1)'(THR_LVL2);
         default: thr_lvl = (AW+1)'(THR_LVL3);
      endcase
      case (cfg.tick_rate_sel)
         2'h0:    div_val = DIV_SEL0;
         2'h1:    div_val = DIV_SEL1;
         2'h2:    div_val = DIV_SEL2;
         default: div_val = DIV_SEL3;
      endcase
   end

   // Capture FIFO; a full write pops the oldest so in_rdy stays high
   pcc_fifo #(
      .W     (ENTRY_W),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_fifo (
      .sys_clk_i   (sys_clk_i),
      .sys_rst_i   (blk_rst),
      .flush_i     (flush),
      .in_valid_i  (code_wr),
      .in_ready_o  (in_rdy),
      .in_data_i   (in_ent),
      .out_valid_o (head_vld),
      .out_ready_i (ec_pop | drop),
      .out_data_o  (head),
      .count_o     (fcount)
   );

   // Block-on bit, from controller or host configuration port
   always_ff @(posedge sys_clk_i) begin
      if (blk_rst) begin
         act <= ACT_RST;
      end else if (ec_wr && ec_addr_i == OFS_ACTIVATE) begin
         act <= ec_wdata_i[ACT_BIT];
      end else if (cfg_wr_i && cfg_index_i == IDX_ACTIVATE) begin
         act <= cfg_wdata_i[ACT_BIT];
      end
   end

   // Configuration control bits, independent of the block-on bit
   always_ff @(posedge sys_clk_i) begin
      if (blk_rst) begin
         cfg <= CFG_RST;
      end else if (ec_wr && ec_addr_i == OFS_CFG) begin
         cfg.thr           <= ec_wdata_i[CFG_THR_LSB +: 2];
         cfg.tmr_en        <= ec_wdata_i[CFG_TMR_BIT];
         cfg.tick_rate_sel <= ec_wdata_i[CFG_RATE_LSB +: 2];
      end
   end

   // Sticky overflow; a new drop wins over the clear
   always_ff @(posedge sys_clk_i) begin
      if (blk_rst) begin
         overrun <= 1'b0;
      end else begin
         overrun <= drop || (overrun && !flush);
      end
   end

   // Tick prescaler, held at zero while the timer is stopped
   always_ff @(posedge sys_clk_i) begin
      if (blk_rst || !run || tick) begin
         presc <= 7'h00;
      end else begin
         presc <= presc + 7'h01;
      end
   end

   // Timestamp counter
   always_ff @(posedge sys_clk_i) begin
      if (blk_rst || !act) begin
         timer <= '0;
      end else if (cnt_ld) begin
         timer <= ec_wdata_i[CNT_LSB +: TIME_W];
      end else if (ts_clr) begin
         timer <= '0;
      end else if (tick) begin
         timer <= timer + 1'b1;
      end
   end

   // Interrupt on fill level, unmasked
   always_ff @(posedge sys_clk_i) begin
      if (blk_rst) begin
         post_code_irq_o <= 1'b0;
      end else begin
         post_code_irq_o <= act && fcount >= thr_lvl;
      end
   end

   // Host side: claim only when on, reads give zero
   always_ff @(posedge sys_clk_i) begin
      if (blk_rst) begin
         host_claim_o <= 1'b0;
         host_rdata_o <= 8'h00;
         cfg_rdata_o  <= 8'h00;
      end else begin
         host_claim_o <= act && (host_wr_i || host_rd_i);
         host_rdata_o <= 8'h00;
         cfg_rdata_o  <= (cfg_rd_i && cfg_index_i == IDX_ACTIVATE) ? {7'h00, act} : 8'h00;
      end
   end

   // Controller read mux, answered one cycle after the strobe
   always_ff @(posedge sys_clk_i) begin
      if (blk_rst) begin
         ec_ack_o   <= 1'b0;
         ec_rdata_o <= 32'h0000_0000;
      end else begin
         ec_ack_o   <= ec_req_i;
         ec_rdata_o <= 32'h0000_0000;
         if (ec_rd) begin
            case (ec_addr_i)
               OFS_FIFO_OUT: ec_rdata_o <= head_vld ? head : 32'h0000_0000;
               OFS_CFG:      ec_rdata_o <= 32'({cfg.thr, cfg.tmr_en, cfg.tick_rate_sel, 3'h0});
               OFS_STATE:    ec_rdata_o <= 32'({overrun, head_vld});
               OFS_COUNT:    ec_rdata_o <= {timer, 8'h00};
               OFS_ACTIVATE: ec_rdata_o <= 32'(act);
               default:      ec_rdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Properties, all quiet while the block is held in reset
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (blk_rst);

   sequence s_thr_top;
      act && cfg.thr == 2'h3;
   endsequence
   sequence s_fill;
      act && fcount >= thr_lvl;
   endsequence
   sequence s_run8;
      (run && cfg.tick_rate_sel == 2'h0 && !cnt_ld && !ts_clr && presc == 7'h00) ##1
      (run && cfg.tick_rate_sel == 2'h0 && !cnt_ld && !ts_clr) [*8];
   endsequence

   a_irq_level: assert property (s_fill |=> post_code_irq_o)
      else $error("interrupt missing at fill level");
   a_irq_off: assert property (!act || fcount < thr_lvl |=> !post_code_irq_o)
      else $error("interrupt without cause");
   a_host_zero: assert property (host_rd_i |=> host_rdata_o == 8'h00)
      else $error("host read not zero");
   a_drop_keep: assert property (drop && !ec_pop && !flush |=> full && overrun)
      else $error("full write lost count or overflow");
   a_fifo_rdy: assert property (code_wr |-> in_rdy)
      else $error("code write refused by the FIFO");
   a_push_grow: assert property (code_wr && !full && !ec_pop && !flush |=>
      fcount == $past(fcount) + 1'b1)
      else $error("code write not pushed");
   a_pop_adv: assert property (ec_pop && !code_wr && !flush |=>
      fcount == $past(fcount) - 1'b1)
      else $error("read did not advance");
   a_off_idle: assert property (!act |=> fcount == '0 && timer == '0 && !host_claim_o)
      else $error("inactive block not idle");
   a_cnt_load: assert property (cnt_ld && act |=>
      timer == TIME_W'($past(ec_wdata_i) >> CNT_LSB))
      else $error("count load failed");
   a_tick_rate: assert property (s_run8 |-> timer == $past(timer, 8) + 1'b1)
      else $error("timer rate wrong");
   a_status_ne: assert property (ec_rd && ec_addr_i == OFS_STATE |=>
      ec_rdata_o[ST_NE_BIT] == $past(head_vld) && ec_ack_o)
      else $error("not-empty status wrong");
   a_status_ovr: assert property (ec_rd && ec_addr_i == OFS_STATE |=>
      ec_rdata_o[ST_OVR_BIT] == $past(overrun))
      else $error("overflow status wrong");
   a_ack_next: assert property (ec_req_i |=> ec_ack_o)
      else $error("controller access not acknowledged");
   a_code_zero: assert property (ec_rd && ec_addr_i == OFS_HOST_CODE |=>
      ec_rdata_o == '0)
      else $error("code byte register read not zero");
   a_thr_top: assert property (s_thr_top |=>
      post_code_irq_o == ($past(fcount) >= (AW+1)'(THR_LVL3)))
      else $error("top threshold interrupt wrong");
   a_thr_one: assert property (act && cfg.thr == 2'h0 |=>
      post_code_irq_o == $past(head_vld))
      else $error("single entry threshold interrupt wrong");
endmodule // pcc_capture

`default_nettype wire

/* pcc_host_model.sv */
// Host-side partner: code-port I/O cycles and configuration-port accesses
`timescale 1ns/1ns
`default_nettype none
module pcc_host_model (
   input  wire logic       sys_clk_i,   // System clock
   input  wire logic       claim_i,     // Cycle claimed by the block
   input  wire logic [7:0] rdata_i,     // Code port read data
   input  wire logic [7:0] cfg_rdata_i, // Config read data
   output var  logic       wr_o,        // Code write strobe
   output var  logic       rd_o,        // Code read strobe
   output var  logic [7:0] wdata_o,     // Code byte
   output var  logic       cfg_wr_o,    // Config write, device selected
   output var  logic       cfg_rd_o,    // Config read, device selected
   output var  logic [7:0] cfg_index_o, // Config index
   output var  logic [7:0] cfg_wdata_o  // Config write data
);
   logic dev_sel; // Logical device number of this block is selected
   // Idle bus at time zero
   initial begin
      {wr_o, rd_o, cfg_wr_o, cfg_rd_o, dev_sel} = '0;
      {wdata_o, cfg_index_o, cfg_wdata_o} = '0;
   end
   // Selects the logical device before any index access
   task automatic select_device(input logic s);
      dev_sel = s;
   endtask
   // One I/O cycle on the code port; claim and data come one cycle later
   task automatic code_io(input logic wr, input logic [7:0] b, output logic claim,
                          output logic [7:0] q);
      @(negedge sys_clk_i);
      wr_o = wr;
      rd_o = !wr;
      wdata_o = b;
      @(negedge sys_clk_i);
      {wr_o, rd_o} = 2'h0;
      wdata_o = ~b; // Released bus must not show the old byte
      claim = claim_i;
      q = rdata_i;
   endtask
   // One configuration access, only while the device is selected
   task automatic cfg_io(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                         output logic [7:0] q);
      @(negedge sys_clk_i);
      cfg_wr_o = wr & dev_sel;
      cfg_rd_o = !wr & dev_sel;
      cfg_index_o = idx;
      cfg_wdata_o = d;
      @(negedge sys_clk_i);
      {cfg_wr_o, cfg_rd_o} = 2'h0;
      cfg_index_o = ~idx;
      cfg_wdata_o = ~d;
      q = cfg_rdata_i;
   endtask
endmodule // pcc_host_model
`default_nettype wire

/* pcc_capture_tb.sv */
// Self-checking bench for the POST-code capture block
`timescale 1ns/1ns
`default_nettype none
module pcc_capture_tb import pcc_pkg::*;;
   logic        sys_clk, sys_rst, stby, pgood, hrst, ovr, claim, irq;
   logic        host_wr, host_rd, host_claim, cfg_wr, cfg_rd, ec_req, ec_wr, ec_ack;
   logic [7:0]  host_wdata, host_rdata, cfg_index, cfg_wdata, cfg_rdata, c8;
   logic [11:0] ec_addr;
   logic [31:0] ec_wdata, ec_rdata, r, t0;
   logic [23:0] tload;
   logic [31:0] exp_q[$];
   integer      seed = 69, bad_count = 0, compares = 0, i, d;

   pcc_capture pcc_capture_i (
      .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .standby_supply_i(stby),
      .power_good_in_i(pgood), .host_if_reset_i(hrst), .host_wr_i(host_wr),
      .host_rd_i(host_rd), .host_wdata_i(host_wdata), .host_claim_o(host_claim),
      .host_rdata_o(host_rdata), .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd),
      .cfg_index_i(cfg_index), .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata),
      .ec_req_i(ec_req), .ec_wr_i(ec_wr), .ec_addr_i(ec_addr), .ec_wdata_i(ec_wdata),
      .ec_ack_o(ec_ack), .ec_rdata_o(ec_rdata), .post_code_irq_o(irq));
   pcc_host_model pcc_host_model_i (
      .sys_clk_i(sys_clk), .claim_i(host_claim), .rdata_i(host_rdata),
      .cfg_rdata_i(cfg_rdata), .wr_o(host_wr), .rd_o(host_rd), .wdata_o(host_wdata),
      .cfg_wr_o(cfg_wr), .cfg_rd_o(cfg_rd), .cfg_index_o(cfg_index),
      .cfg_wdata_o(cfg_wdata));

   // Clock at 250 MHz
   initial begin
      sys_clk = 1'h0;
      forever #2 sys_clk = ~sys_clk;
   end
   // Fill level that raises the interrupt for a threshold select
   function automatic int lvl(input logic [1:0] s);
      return (s == 2'h3) ? 14 : (s == 2'h2) ? 8 : (s == 2'h1) ? 4 : 1;
   endfunction
   // Compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // Controller access: strobe for one clock, wait a bounded time for ack
   task automatic ec_acc(input logic wr, input logic [11:0] a, input logic [31:0] dat,
                         output logic [31:0] q);
      @(negedge sys_clk);
      ec_req = 1'h1;
      ec_wr = wr;
      ec_addr = a;
      ec_wdata = dat;
      @(negedge sys_clk);
      ec_req = 1'h0;
      ec_wdata = ~dat;
      repeat (3) if (ec_ack !== 1'h1) @(negedge sys_clk);
      chk(ec_ack, 1'h1);
      q = ec_rdata;
   endtask
   // Host code write with reference model of the FIFO and interrupt
   task automatic push(input logic [7:0] v, input logic [1:0] thr);
      pcc_host_model_i.code_io(1'h1, v, claim, c8);
      chk(claim, 1'h1);
      if (exp_q.size() == 16) begin
         void'(exp_q.pop_front());
         ovr = 1'h1;
      end
      exp_q.push_back({tload, v});
      @(negedge sys_clk);
      chk(irq, exp_q.size() >= lvl(thr));
   endtask
   // Verdict
   task automatic summarize();
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      #100000;
      bad_count++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      summarize();
   end
   // Main sequence
   initial begin
      {sys_rst, stby, pgood, hrst} = 4'hE;
      {ec_req, ec_wr, ec_addr, ec_wdata, ovr, tload} = '0;
      repeat (16) @(negedge sys_clk);
      sys_rst = 1'h0;
      repeat (6) @(negedge sys_clk);
      // Block off after reset: code writes unclaimed, nothing stored
      ec_acc(1'h0, OFS_ACTIVATE, 32'h0, r);
      chk(r, 32'h0);
      pcc_host_model_i.code_io(1'h1, 8'h5A, claim, c8);
      chk(claim, 1'h0);
      ec_acc(1'h0, OFS_STATE, 32'h0, r);
      chk(r, 32'h0);
      // Host enables the block through the configuration port
      pcc_host_model_i.select_device(1'h1);
      pcc_host_model_i.cfg_io(1'h1, IDX_ACTIVATE, 8'h01, c8);
      pcc_host_model_i.cfg_io(1'h0, IDX_ACTIVATE, 8'h00, c8);
      chk(c8, 8'h01);
      // Each threshold: overfill with random codes, then drain or flush
      for (int t = 0; t < 4; t++) begin
         ec_acc(1'h1, OFS_CFG, 32'((t << 6) | (t << 3) | 2), r);
         ovr = 1'h0;
         exp_q.delete();
         ec_acc(1'h0, OFS_CFG, 32'h0, r);
         chk(r, 32'((t << 6) | (t << 3)));
         tload = 24'($random(seed));
         ec_acc(1'h1, OFS_COUNT, {tload, 8'h00}, r);
         ec_acc(1'h0, OFS_COUNT, 32'h0, r);
         chk(r, {tload, 8'h00});
         for (i = 0; i < 18; i++) push(8'($random(seed)), 2'(t));
         ec_acc(1'h0, OFS_STATE, 32'h0, r);
         chk(r, {30'h0, ovr, 1'h1});
         if (t[0]) begin
            ec_acc(1'h1, OFS_CFG, 32'h2, r);
            exp_q.delete();
            ovr = 1'h0;
         end
         while (exp_q.size() > 0) begin
            ec_acc(1'h0, OFS_FIFO_OUT, 32'h0, r);
            chk(r, exp_q.pop_front());
         end
         ec_acc(1'h0, OFS_STATE, 32'h0, r);
         chk(r, {30'h0, ovr, 1'h0});
      end
      ec_acc(1'h0, OFS_FIFO_OUT, 32'h0, r);
      chk(r, 32'h0);
      ec_acc(1'h0, 12'h200, 32'h0, r);
      chk(r, 32'h0);
      ec_acc(1'h0, OFS_HOST_CODE, 32'h0, r);
      chk(r, 32'h0);
      pcc_host_model_i.code_io(1'h0, 8'h00, claim, c8);
      chk({claim, c8}, 32'h100);
      ec_acc(1'h1, OFS_HOST_CODE, 32'h3C, r);
      ec_acc(1'h0, OFS_FIFO_OUT, 32'h0, r);
      chk(r, {tload, 8'h3C});
      // Timer tick rate for every select value
      for (int s = 0; s < 4; s++) begin
         ec_acc(1'h1, OFS_CFG, 32'h24 | 32'(s << 3), r);
         ec_acc(1'h0, OFS_COUNT, 32'h0, t0);
         chk(32'(t0[31:8] <= 24'h1), 32'h1);
         repeat (4 * (8 << s)) @(negedge sys_clk);
         ec_acc(1'h0, OFS_COUNT, 32'h0, r);
         d = int'(r[31:8] - t0[31:8]);
         chk(32'(d == 4 || d == 5), 32'h1);
      end
      // Block off again: FIFO and timer cleared, control bits kept
      push(8'h77, 2'h0);
      pcc_host_model_i.cfg_io(1'h1, IDX_ACTIVATE, 8'h00, c8);
      ec_acc(1'h0, OFS_STATE, 32'h0, r);
      chk(r, 32'h0);
      ec_acc(1'h0, OFS_COUNT, 32'h0, r);
      chk(r, 32'h0);
      ec_acc(1'h0, OFS_CFG, 32'h0, r);
      chk(r, 32'h38);
      chk(irq, 1'h0);
      // Each reset source clears the block
      for (int p = 0; p < 3; p++) begin
         ec_acc(1'h1, OFS_ACTIVATE, 32'h1, r);
         exp_q.delete();
         push(8'(p), 2'h0);
         {stby, pgood, hrst} = 3'h6 ^ (3'h4 >> p);
         repeat (8) @(negedge sys_clk);
         {stby, pgood, hrst} = 3'h6;
         repeat (8) @(negedge sys_clk);
         ec_acc(1'h0, OFS_ACTIVATE, 32'h0, r);
         chk(r, 32'h0);
         ec_acc(1'h0, OFS_STATE, 32'h0, r);
         chk(r, 32'h0);
      end
      summarize();
   end
endmodule // pcc_capture_tb
`default_nettype wire
